//--- hdl/ledc_defines.svh
// register offsets, field positions, reset values and clock frequency of the led driver config bank
`ifndef LEDC_DEFINES_SVH
`define LEDC_DEFINES_SVH

`define LEDC_ADDR_W           8
`define LEDC_DATA_W           8

`define LEDC_OFS_DIAG_LO      8'hc4
`define LEDC_OFS_DIAG_HI      8'hc5
`define LEDC_OFS_REG_DIM_ADDR 8'hc6
`define LEDC_OFS_PWM_POL_REF  8'hc7

`define LEDC_RST_DIAG_LO      8'hff
`define LEDC_RST_DIAG_HI      8'h0f
`define LEDC_RST_REG_DIM_ADDR 8'h00
`define LEDC_RST_PWM_POL_REF  8'ha7

`define LEDC_MASK_DIAG_LO      8'hff
`define LEDC_MASK_DIAG_HI      8'h0f
`define LEDC_MASK_REG_DIM_ADDR 8'h5f
`define LEDC_MASK_PWM_POL_REF  8'hff

`define LEDC_BIT_REG_VSEL     6
`define LEDC_BIT_EXP_DIM      4
`define LEDC_MSB_STORED_ADDR  3
`define LEDC_LSB_STORED_ADDR  0
`define LEDC_MSB_PWM_FREQ     7
`define LEDC_LSB_PWM_FREQ     4
`define LEDC_BIT_ADDR_SRC     3
`define LEDC_BIT_FAIL_POLICY  2
`define LEDC_MSB_REF_RATIO    1
`define LEDC_LSB_REF_RATIO    0

`define LEDC_CLK_HZ           20000000

`endif

//--- hdl/ledc_pkg.sv
// types shared by the led driver config bank
package ledc_pkg;

  typedef struct packed {
    logic [11:0] diag_en;
    logic        regulator_voltage_select;
    logic        exponential_dimming_enable;
    logic [3:0]  bus_address;
    logic        address_source_select;
    logic [3:0]  pwm_frequency_code;
    logic        output_failure_policy;
    logic [1:0]  reference_ratio_code;
  } ledc_cfg_t;

  typedef enum logic [1:0] {
    LEDC_RATIO_64,
    LEDC_RATIO_128,
    LEDC_RATIO_256,
    LEDC_RATIO_512
  } ledc_ratio_t;

endpackage

//--- hdl/ledc_pwm_period.sv
// maps the pwm frequency code to a pwm period length in reference clock cycles
`include "ledc_defines.svh"

module ledc_pwm_period #(
  parameter int CLK_HZ = `LEDC_CLK_HZ
) (
  input  wire logic [3:0]  pwm_frequency_code,
  output wire logic [19:0] period_cycles
);

  // ---------------------------------------------------------------
  // period table, frequencies in tenths of hertz to keep 5.9 kHz exact
  // ---------------------------------------------------------------
  function automatic logic [19:0] ledc_period(input logic [3:0] code);
    int unsigned dhz;
    dhz = 0;
    case (code)
      4'h0: dhz = 2000;
      4'h1: dhz = 2500;
      4'h2: dhz = 3000;
      4'h3: dhz = 3500;
      4'h4: dhz = 4000;
      4'h5: dhz = 5000;
      4'h6: dhz = 6000;
      4'h7: dhz = 8000;
      4'h8: dhz = 10000;
      4'h9: dhz = 12000;
      4'ha: dhz = 20000;
      4'hb: dhz = 40000;
      4'hc: dhz = 59000;
      4'hd: dhz = 78000;
      4'he: dhz = 96000;
      4'hf: dhz = 208000;
      default: dhz = 20000;
    endcase
    // period rounds down to whole cycles; nothing holds it at one cycle or more
    ledc_period = 20'((64'(CLK_HZ) * 64'd10) / 64'(dhz));
  endfunction

  assign period_cycles = ledc_period(pwm_frequency_code);

endmodule

//--- hdl/ledc_cfg_bank.sv
// non-volatile configuration register group of a 12-channel led driver
//
// Summary of operation
// - diagnostics enable for channels 0-7, bit n is channel n, default enabled
// - diagnostics enable for channels 8-11 in bits 3-0; bits 7-4 read zero
// - bit 6 selects regulator target: 0 gives 5.0 V, 1 gives 4.4 V; default 0
// - bit 4 selects linear (0, default) or exponential (1) dimming
// - bits 3-0 hold a stored four-bit bus address, default 0
// - address source: 0 uses three strap pins, 1 uses stored address field
// - bits 7-4 select pwm frequency from 200 Hz to 20.8 kHz, default code a
// - bit 2 fault policy: 0 others stay on, 1 all off; default 1
// - bits 1-0 reference ratio 64/128/256/512, default code 3
//
// Chosen here: the address-and-strobe port.
`include "ledc_defines.svh"

module ledc_cfg_bank #(
  parameter int CLK_HZ = `LEDC_CLK_HZ
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  input  wire logic [`LEDC_ADDR_W-1:0]   reg_addr,
  input  wire logic [`LEDC_DATA_W-1:0]   reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [`LEDC_DATA_W-1:0]   reg_rdata,
  input  wire logic                      address_strap_pin_0,
  input  wire logic                      address_strap_pin_1,
  input  wire logic                      address_strap_pin_2,
  output ledc_pkg::ledc_cfg_t            cfg,
  output logic      [3:0]                active_bus_address,
  output logic      [11:0]               diag_enable,
  output logic                           regulator_low_voltage,
  output logic                           exponential_dimming,
  output logic                           all_fail_on_fault,
  output logic      [9:0]                reference_ratio,
  output logic      [19:0]               pwm_period_cycles
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] diag_enable_low_channels;
  logic [7:0] diag_enable_high_channels;
  logic [7:0] regulator_dimming_address_cfg;
  logic [7:0] pwm_freq_policy_ratio_cfg;

  // strap synchroniser; the first stage is read only by the second
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // one-hot register select, shared by the write enables and the read mux
  function automatic logic [3:0] ledc_select(input logic [7:0] ofs);
    logic [3:0] sel;
    sel = 4'h0;
    case (ofs)
      `LEDC_OFS_DIAG_LO:      sel = 4'h1;
      `LEDC_OFS_DIAG_HI:      sel = 4'h2;
      `LEDC_OFS_REG_DIM_ADDR: sel = 4'h4;
      `LEDC_OFS_PWM_POL_REF:  sel = 4'h8;
      default:                sel = 4'h0;
    endcase
    return sel;
  endfunction

  wire logic [3:0] reg_sel = ledc_select(reg_addr);

  wire logic hit_diag_lo = reg_sel[0];
  wire logic hit_diag_hi = reg_sel[1];
  wire logic hit_rda     = reg_sel[2];
  wire logic hit_ppr     = reg_sel[3];

  wire logic wr_diag_lo = reg_wr & hit_diag_lo;
  wire logic wr_diag_hi = reg_wr & hit_diag_hi;
  wire logic wr_rda     = reg_wr & hit_rda;
  wire logic wr_ppr     = reg_wr & hit_ppr;

  // ---------------------------------------------------------------
  // field masks
  // ---------------------------------------------------------------
  // one decode of the writable bits serves writes and reads alike,
  // so a reserved bit can neither be stored nor leak out on a read
  function automatic logic [7:0] ledc_live_bits(input logic [7:0] ofs);
    logic [7:0] bits;
    bits = 8'h00;
    case (ofs)
      `LEDC_OFS_DIAG_LO:      bits = `LEDC_MASK_DIAG_LO;
      `LEDC_OFS_DIAG_HI:      bits = `LEDC_MASK_DIAG_HI;
      `LEDC_OFS_REG_DIM_ADDR: bits = `LEDC_MASK_REG_DIM_ADDR;
      `LEDC_OFS_PWM_POL_REF:  bits = `LEDC_MASK_PWM_POL_REF;
      default:                bits = 8'h00;
    endcase
    return bits;
  endfunction

  wire logic [7:0] live_bits  = ledc_live_bits(reg_addr);
  wire logic [7:0] next_wdata = reg_wdata & live_bits;

  // unmapped addresses read zero
  wire logic [7:0] raw_rdata =
    hit_diag_lo ? diag_enable_low_channels :
    hit_diag_hi ? diag_enable_high_channels :
    hit_rda     ? regulator_dimming_address_cfg :
    hit_ppr     ? pwm_freq_policy_ratio_cfg :
                  8'h00;
  wire logic [7:0] next_rdata = raw_rdata & live_bits;

  // ---------------------------------------------------------------
  // field extraction
  // ---------------------------------------------------------------
  wire logic [3:0] stored_bus_address =
    regulator_dimming_address_cfg[`LEDC_MSB_STORED_ADDR:`LEDC_LSB_STORED_ADDR];
  wire logic       address_source_select = pwm_freq_policy_ratio_cfg[`LEDC_BIT_ADDR_SRC];
  wire logic [3:0] strap_address = {1'b0, strap_sync};
  wire logic [3:0] next_active_addr =
    address_source_select ? stored_bus_address : strap_address;

  wire logic [3:0] pwm_frequency_code =
    pwm_freq_policy_ratio_cfg[`LEDC_MSB_PWM_FREQ:`LEDC_LSB_PWM_FREQ];
  wire logic [1:0] reference_ratio_code =
    pwm_freq_policy_ratio_cfg[`LEDC_MSB_REF_RATIO:`LEDC_LSB_REF_RATIO];

  function automatic logic [9:0] ledc_ratio_value(input logic [1:0] code);
    logic [9:0] ratio;
    ratio = 10'h200;
    case (ledc_pkg::ledc_ratio_t'(code))
      ledc_pkg::LEDC_RATIO_64:  ratio = 10'h040;
      ledc_pkg::LEDC_RATIO_128: ratio = 10'h080;
      ledc_pkg::LEDC_RATIO_256: ratio = 10'h100;
      ledc_pkg::LEDC_RATIO_512: ratio = 10'h200;
      default:                  ratio = 10'h200;
    endcase
    return ratio;
  endfunction

  wire logic [9:0] next_ratio = ledc_ratio_value(reference_ratio_code);

  wire logic [11:0] next_diag = {diag_enable_high_channels[3:0], diag_enable_low_channels};

  // ---------------------------------------------------------------
  // pwm period
  // ---------------------------------------------------------------
  wire logic [19:0] period_comb;

  ledc_pwm_period #(
    .CLK_HZ (CLK_HZ)
  ) u_period (
    .pwm_frequency_code (pwm_frequency_code),
    .period_cycles      (period_comb)
  );

  // ---------------------------------------------------------------
  // configuration word
  // ---------------------------------------------------------------
  ledc_pkg::ledc_cfg_t next_cfg;
  always_comb begin
    next_cfg.diag_en                    = next_diag;
    next_cfg.regulator_voltage_select   = regulator_dimming_address_cfg[`LEDC_BIT_REG_VSEL];
    next_cfg.exponential_dimming_enable = regulator_dimming_address_cfg[`LEDC_BIT_EXP_DIM];
    next_cfg.bus_address                = stored_bus_address;
    next_cfg.address_source_select      = address_source_select;
    next_cfg.pwm_frequency_code         = pwm_frequency_code;
    next_cfg.output_failure_policy      = pwm_freq_policy_ratio_cfg[`LEDC_BIT_FAIL_POLICY];
    next_cfg.reference_ratio_code       = reference_ratio_code;
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // one short process per register keeps each write enable beside its reset value
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      diag_enable_low_channels <= `LEDC_RST_DIAG_LO;
    end else if (wr_diag_lo) begin
      diag_enable_low_channels <= next_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      diag_enable_high_channels <= `LEDC_RST_DIAG_HI;
    end else if (wr_diag_hi) begin
      diag_enable_high_channels <= next_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regulator_dimming_address_cfg <= `LEDC_RST_REG_DIM_ADDR;
    end else if (wr_rda) begin
      regulator_dimming_address_cfg <= next_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pwm_freq_policy_ratio_cfg <= `LEDC_RST_PWM_POL_REF;
    end else if (wr_ppr) begin
      pwm_freq_policy_ratio_cfg <= next_wdata;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // read data is valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // strap pins
  // ---------------------------------------------------------------
  // straps are asynchronous to ref_clk, so each pin passes two flops before the address mux
  wire logic [2:0] strap_pins = {address_strap_pin_2, address_strap_pin_1, address_strap_pin_0};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_strap
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          strap_meta[gi] <= 1'b0;
          strap_sync[gi] <= 1'b0;
        end else begin
          strap_meta[gi] <= strap_pins[gi];
          strap_sync[gi] <= strap_meta[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  // outputs trail the registers by one cycle so each comes from a flop
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      active_bus_address <= 4'h0;
    end else begin
      active_bus_address <= next_active_addr;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      diag_enable <= 12'h000;
    end else begin
      diag_enable <= next_diag;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regulator_low_voltage <= 1'b0;
    end else begin
      regulator_low_voltage <= next_cfg.regulator_voltage_select;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      exponential_dimming <= 1'b0;
    end else begin
      exponential_dimming <= next_cfg.exponential_dimming_enable;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      all_fail_on_fault <= 1'b0;
    end else begin
      all_fail_on_fault <= next_cfg.output_failure_policy;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reference_ratio <= 10'h000;
    end else begin
      reference_ratio <= next_ratio;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pwm_period_cycles <= 20'h00000;
    end else begin
      pwm_period_cycles <= period_comb;
    end
  end

endmodule

//--- verification/ledc_cfg_bank_chk.sv
// port checker for the led config bank
module ledc_cfg_bank_chk (
  input wire logic                ref_clk,
  input wire logic                rstn,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire ledc_pkg::ledc_cfg_t cfg,
  input wire logic [3:0]          active_bus_address,
  input wire logic [11:0]         diag_enable,
  input wire logic                regulator_low_voltage,
  input wire logic                exponential_dimming,
  input wire logic                all_fail_on_fault,
  input wire logic [9:0]          reference_ratio
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // field outputs follow a write two edges later
  property p_hi_rsvd; $past(reg_rd) && $past(reg_addr) == 8'hc5 |-> reg_rdata[7:4] == 4'h0; endproperty
  a_hi_rsvd: assert property (p_hi_rsvd) else $error("c5 upper bits not zero");
  property p_c6_rsvd; $past(reg_rd) && $past(reg_addr) == 8'hc6 |-> !reg_rdata[7] && !reg_rdata[5]; endproperty
  a_c6_rsvd: assert property (p_c6_rsvd) else $error("c6 reserved bits not zero");
  property p_diag_lo; reg_wr && reg_addr == 8'hc4 |-> ##2 diag_enable[7:0] == $past(reg_wdata, 2); endproperty
  a_diag_lo: assert property (p_diag_lo) else $error("low diag enables wrong");
  property p_diag_hi; reg_wr && reg_addr == 8'hc5 |-> ##2 diag_enable[11:8] == $past(reg_wdata[3:0], 2); endproperty
  a_diag_hi: assert property (p_diag_hi) else $error("high diag enables wrong");
  property p_vsel; reg_wr && reg_addr == 8'hc6 |-> ##2 regulator_low_voltage == $past(reg_wdata[6], 2); endproperty
  a_vsel: assert property (p_vsel) else $error("regulator select wrong");
  property p_exp; reg_wr && reg_addr == 8'hc6 |-> ##2 exponential_dimming == $past(reg_wdata[4], 2); endproperty
  a_exp: assert property (p_exp) else $error("dimming mode wrong");
  property p_freq; reg_wr && reg_addr == 8'hc7 |-> ##2 cfg.pwm_frequency_code == $past(reg_wdata[7:4], 2); endproperty
  a_freq: assert property (p_freq) else $error("pwm code wrong");
  property p_policy; reg_wr && reg_addr == 8'hc7 |-> ##2 all_fail_on_fault == $past(reg_wdata[2], 2); endproperty
  a_policy: assert property (p_policy) else $error("fault policy wrong");
  property p_ratio; reg_wr && reg_addr == 8'hc7 |-> ##2 reference_ratio == 10'h040 << $past(reg_wdata[1:0], 2); endproperty
  a_ratio: assert property (p_ratio) else $error("reference ratio wrong");
  property p_src; cfg.address_source_select |-> active_bus_address == cfg.bus_address; endproperty
  a_src: assert property (p_src) else $error("stored address not used");
endmodule

bind ledc_cfg_bank ledc_cfg_bank_chk u_chk (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .cfg, .active_bus_address, .diag_enable, .regulator_low_voltage, .exponential_dimming, .all_fail_on_fault,
  .reference_ratio);

//--- verification/ledc_cfg_bank_tb.sv
// random self-checking bench for the led config bank
module ledc_cfg_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                ref_clk, rstn, reg_wr, reg_rd, lowv, expd, allf;
  logic [7:0]          reg_addr, reg_wdata, reg_rdata;
  logic [2:0]          strap;
  logic [3:0]          abus;
  logic [9:0]          ratio;
  logic [11:0]         diag;
  logic [19:0]         period;
  logic [31:0]         seed, r;
  logic [7:0]          m [4];
  ledc_pkg::ledc_cfg_t cfg, ecfg;
  int                  bad_count, checks;
  // pwm rates in tenths of a hertz, code order
  localparam int F10[16] = '{2000, 2500, 3000, 3500, 4000, 5000, 6000, 8000, 10000, 12000,
                             20000, 40000, 59000, 78000, 96000, 208000};

  ledc_cfg_bank dut (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .address_strap_pin_0(strap[0]), .address_strap_pin_1(strap[1]), .address_strap_pin_2(strap[2]), .cfg,
    .active_bus_address(abus), .diag_enable(diag), .regulator_low_voltage(lowv), .exponential_dimming(expd),
    .all_fail_on_fault(allf), .reference_ratio(ratio), .pwm_period_cycles(period));

  initial begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // writable bits per offset; reserved and unmapped bits drop out
  function logic [7:0] msk(logic [7:0] a);
    case (a)
      8'hc4, 8'hc7: return 8'hff;
      8'hc5: return 8'h0f;
      8'hc6: return 8'h5f;
      default: return 8'h00;
    endcase
  endfunction

  function logic [7:0] exp_rd(logic [7:0] a);
    return (msk(a) != 8'h00) ? m[a[1:0]] : 8'h00;
  endfunction

  // expected config word, field by field from the shadow registers
  function ledc_pkg::ledc_cfg_t exp_cfg();
    ledc_pkg::ledc_cfg_t c;
    c.diag_en                    = {m[1][3:0], m[0]};
    c.regulator_voltage_select   = m[2][6];
    c.exponential_dimming_enable = m[2][4];
    c.bus_address                = m[2][3:0];
    c.address_source_select      = m[3][3];
    c.pwm_frequency_code         = m[3][7:4];
    c.output_failure_policy      = m[3][2];
    c.reference_ratio_code       = m[3][1:0];
    return c;
  endfunction

  task chk(string n, logic [19:0] e, logic [19:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    if (msk(a) != 8'h00) m[a[1:0]] = d & msk(a);
  endtask

  task rd(logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp_rd(a), reg_rdata);
  endtask

  // four edges cover the write latency and the strap synchroniser
  task outs();
    repeat (4) @(posedge ref_clk);
    #1 chk("diag_enable", {m[1][3:0], m[0]}, diag);
    ecfg = exp_cfg();
    chk("cfg.diag_en", ecfg.diag_en, cfg.diag_en);
    chk("cfg_fields", ecfg[13:0], cfg[13:0]);
    chk("regulator_low_voltage", m[2][6], lowv);
    chk("exponential_dimming", m[2][4], expd);
    chk("active_bus_address", m[3][3] ? m[2][3:0] : {1'b0, strap}, abus);
    chk("pwm_period_cycles", 200000000 / F10[m[3][7:4]], period);
    chk("all_fail_on_fault", m[3][2], allf);
    chk("reference_ratio", 10'h040 << m[3][1:0], ratio);
  endtask

  task print_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #300000;
    bad_count++;
    print_verdict();
  end

  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, strap} = '0;
    seed = 32'h31a39504;
    m = '{8'hff, 8'h0f, 8'h00, 8'ha7};
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    outs();
    for (int a = 8'hc3; a <= 8'hc8; a++) rd(8'(a));
    for (int i = 0; i < 16; i++) begin
      wr(8'hc7, {2{4'(i)}});
      rd(8'hc7);
      outs();
    end
    wr(8'hc5, 8'hff);
    wr(8'hc6, 8'hff);
    rd(8'hc5);
    rd(8'hc6);
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      @(posedge ref_clk);
      strap <= r[2:0];
      wr(8'hc3 + {5'h00, r[10:8]}, r[23:16]);
      rd(8'hc3 + {5'h00, r[10:8]});
      outs();
    end
    // mid-run reset must bring every register back to its reset value
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    m = '{8'hff, 8'h0f, 8'h00, 8'ha7};
    outs();
    rd(8'hc7);
    print_verdict();
  end
endmodule
